// File: shared/vsyn_defines.svh
/*
 * Constants of the voice synthesizer engine: register offsets, field
 * positions, reset values, rates and timing counts.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef VSYN_DEFINES_SVH
`define VSYN_DEFINES_SVH

// timing: system clock and sample rate in their own units
`define VSYN_SYS_CLK_HZ 48000000
`define VSYN_TICK_HZ 15000
`define VSYN_TICK_DIV (`VSYN_SYS_CLK_HZ / `VSYN_TICK_HZ)

// voice and key counts
`define VSYN_NUM_VOICES 10
`define VSYN_NUM_KEYS 37
`define VSYN_SLOT_FREE 8'hFF

// envelope phase is 8.12 fixed point; waveform phase is 8.8
`define VSYN_ENV_SUSTAIN 20'h00038
`define VSYN_ENV_RELEASE 20'h01000

// apb register byte offsets
`define VSYN_ADDR_KEY_EVT 12'h000
`define VSYN_ADDR_VOICE_BUSY 12'h004
`define VSYN_ADDR_MIX 12'h008
`define VSYN_ADDR_STATUS 12'h00C

// key event register fields
`define VSYN_EVT_PRESS_KEY_LSB 0
`define VSYN_EVT_PRESS_EN_BIT 6
`define VSYN_EVT_REL_KEY_LSB 8
`define VSYN_EVT_REL_EN_BIT 14

// status register fields
`define VSYN_STAT_PEND_BIT 0
`define VSYN_STAT_DROP_BIT 1

`endif

// File: shared/vsyn_pkg.sv
/*
 * Types of the voice synthesizer engine: voice record, key event,
 * lookup table shape and sequencer states.
 * Assumes vsyn_defines.svh supplies the numeric constants.
 */
package vsyn_pkg;

    // one voice slot
    typedef struct packed {
        logic [7:0] state;
        logic [15:0] wphase;
        logic [15:0] wstep;
        logic [19:0] ephase;
        logic release_rate;
    } vsyn_voice_type;

    // one scan result as written by software
    typedef struct packed {
        logic rel_en;
        logic [5:0] rel_key;
        logic press_en;
        logic [5:0] press_key;
    } vsyn_key_evt_type;

    typedef logic [255:0][7:0] vsyn_rom_type;

    typedef enum logic [0:0] {
        VSYN_IDLE = 1'b0,
        VSYN_UPDATE = 1'b1
    } vsyn_seq_type;

endpackage

// File: design/vsyn_engine.sv
/*
 * Ten-voice wavetable synthesizer engine with an APB register port.
 * Software writes scan results (one released key, one pressed key);
 * every sample tick the engine steps each voice and mixes the
 * envelope-times-waveform products into one word for an 8-bit DAC.
 * Assumes a single clock pclk and that the APB master keeps the
 * request stable until pready.
 */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "vsyn_defines.svh"

// Overview of operation
// - new mixed sample every 15 kHz tick
// - tick from system clock divided by 3200
// - exactly ten independent voice slots
// - output sums envelope times waveform per voice
// - 256-entry envelope and waveform lookup tables
// - one entry per tick gives 58.5934 Hz
// - 37-entry note step table by key
// - note steps carry 16-bit fixed point
// - sustain rate spans envelope in 1.25 s
// - faster release rate after key let go
// - slot holds key number or 255 free
// - active voice steps envelope phase each tick
// - unfinished voice steps waveform phase each tick
// - envelope rate is sustain or release only
// - accumulator cleared, then sums all products
// - released key switches matching slots to release
// - pressed key loads a free slot
// - press without free slot only sets the drop flag
module vsyn_engine #(
    parameter int unsigned TICK_DIV = `VSYN_TICK_DIV
)(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dac side
    output logic [7:0] mix_output,
    output logic sample_strobe
);
    import vsyn_pkg::*;

    // attack over 16 entries then a linear decay from 255 down to 2
    function automatic vsyn_rom_type build_env();
        vsyn_rom_type r;
        for (int i = 0; i < 256; i++)
        begin
            if (i < 16)
                r[i] = 8'(i * 16);
            else
                r[i] = 8'(255 - ((i - 16) * 255) / 240);
        end
        return r;
    endfunction

    // fundamental triangle with some second harmonic, centred on 128
    function automatic vsyn_rom_type build_wave();
        vsyn_rom_type r;
        int t1;
        int t2;
        for (int i = 0; i < 256; i++)
        begin
            t1 = (i < 128) ? 2 * i : 511 - 2 * i;
            t2 = ((i % 128) < 64) ? 4 * (i % 128) : 511 - 4 * (i % 128);
            r[i] = 8'((3 * t1 + t2) / 4);
        end
        return r;
    endfunction

    // step = freq / 58.5934 in 8.8 fixed point, keys from 131 Hz up
    function automatic logic [15:0] note_step_table(input logic [5:0] k);
        case (k)
            6'h00: note_step_table = 16'h023C;
            6'h01: note_step_table = 16'h025E;
            6'h02: note_step_table = 16'h0282;
            6'h03: note_step_table = 16'h02A8;
            6'h04: note_step_table = 16'h02D0;
            6'h05: note_step_table = 16'h02FB;
            6'h06: note_step_table = 16'h0328;
            6'h07: note_step_table = 16'h0358;
            6'h08: note_step_table = 16'h038B;
            6'h09: note_step_table = 16'h03C1;
            6'h0A: note_step_table = 16'h03FA;
            6'h0B: note_step_table = 16'h0437;
            6'h0C: note_step_table = 16'h0477;
            6'h0D: note_step_table = 16'h04BB;
            6'h0E: note_step_table = 16'h0503;
            6'h0F: note_step_table = 16'h054F;
            6'h10: note_step_table = 16'h05A0;
            6'h11: note_step_table = 16'h05F6;
            6'h12: note_step_table = 16'h0651;
            6'h13: note_step_table = 16'h06B1;
            6'h14: note_step_table = 16'h0716;
            6'h15: note_step_table = 16'h0782;
            6'h16: note_step_table = 16'h07F5;
            6'h17: note_step_table = 16'h086E;
            6'h18: note_step_table = 16'h08EE;
            6'h19: note_step_table = 16'h0976;
            6'h1A: note_step_table = 16'h0A06;
            6'h1B: note_step_table = 16'h0A9F;
            6'h1C: note_step_table = 16'h0B40;
            6'h1D: note_step_table = 16'h0BEC;
            6'h1E: note_step_table = 16'h0CA1;
            6'h1F: note_step_table = 16'h0D61;
            6'h20: note_step_table = 16'h0E2D;
            6'h21: note_step_table = 16'h0F05;
            6'h22: note_step_table = 16'h0FE9;
            6'h23: note_step_table = 16'h10DB;
            6'h24: note_step_table = 16'h11DC;
            default: note_step_table = 16'h0000;
        endcase
    endfunction

    localparam vsyn_rom_type ENV_ROM = build_env();
    localparam vsyn_rom_type WAVE_ROM = build_wave();

    vsyn_voice_type voices [`VSYN_NUM_VOICES];
    vsyn_seq_type seq;
    vsyn_key_evt_type evt;
    logic [15:0] tick_cnt;
    logic tick;
    logic [3:0] vidx;
    logic [19:0] acc;
    logic [19:0] last_mix;
    logic rel_pend;
    logic press_pend;
    logic drop_flag;

    // lowest free slot, 15 when every slot is busy
    function automatic logic [3:0] free_voice_index();
        free_voice_index = 4'hF;
        for (int i = `VSYN_NUM_VOICES - 1; i >= 0; i--)
        begin
            if (voices[i].state == `VSYN_SLOT_FREE)
                free_voice_index = 4'(i);
        end
    endfunction

    // one bit per slot, set while the slot holds a key
    function automatic logic [9:0] busy_map();
        for (int i = 0; i < `VSYN_NUM_VOICES; i++)
            busy_map[i] = (voices[i].state != `VSYN_SLOT_FREE);
    endfunction

    // current voice datapath, one voice per clock
    vsyn_voice_type cur;
    logic [20:0] e_sum;
    logic e_carry;
    logic cur_free;
    logic [15:0] w_next;
    logic [7:0] env_val;
    logic [7:0] wave_val;
    logic [15:0] prod;
    logic [3:0] free_idx;
    logic upd;
    logic rel_go;
    logic press_go;

    always_comb
    begin
        cur = voices[vidx < 4'd10 ? vidx : 4'd0];
        cur_free = (cur.state == `VSYN_SLOT_FREE);
        e_sum = {1'b0, cur.ephase}
              + {1'b0, cur.release_rate ? `VSYN_ENV_RELEASE
                                        : `VSYN_ENV_SUSTAIN};
        e_carry = e_sum[20];
        w_next = cur.wphase + cur.wstep;
        if (cur_free || e_carry)
        begin
            env_val = 8'h00;
            wave_val = 8'h00;
        end
        else
        begin
            env_val = ENV_ROM[e_sum[19:12]];
            wave_val = WAVE_ROM[w_next[15:8]];
        end
        prod = env_val * wave_val;
        free_idx = free_voice_index();
    end

    // key events run only in idle cycles with no tick pending
    assign upd = (seq == VSYN_UPDATE);
    assign rel_go = (seq == VSYN_IDLE) && !tick && rel_pend;
    assign press_go = (seq == VSYN_IDLE) && !tick && !rel_pend
                    && press_pend;

    // sample tick divider; the divisor sets the overall pitch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
        end
        else if (tick_cnt == 16'(TICK_DIV - 1))
        begin
            tick_cnt <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // sequencer and multiply-accumulate over the ten slots
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq <= VSYN_IDLE;
            vidx <= 4'h0;
            acc <= 20'h00000;
            last_mix <= 20'h00000;
            mix_output <= 8'h00;
            sample_strobe <= 1'b0;
        end
        else
        begin
            sample_strobe <= 1'b0;
            case (seq)
                VSYN_IDLE:
                begin
                    if (tick)
                    begin
                        seq <= VSYN_UPDATE;
                        vidx <= 4'h0;
                        acc <= 20'h00000;
                    end
                end
                VSYN_UPDATE:
                begin
                    if (vidx == 4'd9)
                    begin
                        // top bits of the full sum feed the 8-bit dac
                        last_mix <= acc + {4'h0, prod};
                        mix_output <= 8'((acc + {4'h0, prod}) >> 12);
                        sample_strobe <= 1'b1;
                        seq <= VSYN_IDLE;
                    end
                    else
                    begin
                        acc <= acc + {4'h0, prod};
                        vidx <= vidx + 4'h1;
                    end
                end
                default:
                    seq <= VSYN_IDLE;
            endcase
        end
    end

    // voice slot state: stepping on update, assignment on key events
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `VSYN_NUM_VOICES; i++)
            begin
                voices[i].state <= `VSYN_SLOT_FREE;
                voices[i].wphase <= 16'h0000;
                voices[i].wstep <= 16'h0000;
                voices[i].ephase <= 20'h00000;
                voices[i].release_rate <= 1'b0;
            end
        end
        else if (upd && !cur_free)
        begin
            if (e_carry)
                voices[vidx].state <= `VSYN_SLOT_FREE;
            else
            begin
                voices[vidx].ephase <= e_sum[19:0];
                voices[vidx].wphase <= w_next;
            end
        end
        else if (rel_go)
        begin
            // every slot holding the key fades, none is cut short
            for (int i = 0; i < `VSYN_NUM_VOICES; i++)
            begin
                if (voices[i].state == {2'b00, evt.rel_key})
                    voices[i].release_rate <= 1'b1;
            end
        end
        else if (press_go && free_idx != 4'hF)
        begin
            voices[free_idx].state <= {2'b00, evt.press_key};
            voices[free_idx].ephase <= 20'h00000;
            voices[free_idx].wphase <= 16'h0000;
            voices[free_idx].release_rate <= 1'b0;
            voices[free_idx].wstep <=
                note_step_table(evt.press_key);
        end
    end

    // apb slave: one wait state; a new scan result waits for the last
    logic acc_phase;
    logic evt_wr;
    logic stall;
    assign acc_phase = psel && penable && !pready;
    assign evt_wr = pwrite && (paddr == `VSYN_ADDR_KEY_EVT);
    assign stall = evt_wr && (rel_pend || press_pend);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= acc_phase && !stall;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (acc_phase && !stall)
            begin
                case (paddr)
                    `VSYN_ADDR_KEY_EVT: prdata <= 32'h00000000;
                    `VSYN_ADDR_VOICE_BUSY: prdata <= {22'h000000, busy_map()};
                    `VSYN_ADDR_MIX: prdata <= {12'h000, last_mix};
                    `VSYN_ADDR_STATUS:
                        prdata <= {30'h00000000, drop_flag,
                                   rel_pend || press_pend};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // pending scan result; writes take effect at the pready edge
    logic evt_take;
    assign evt_take = psel && penable && pready && evt_wr;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt <= '0;
            rel_pend <= 1'b0;
            press_pend <= 1'b0;
        end
        else if (evt_take)
        begin
            evt.press_key <= pwdata[`VSYN_EVT_PRESS_KEY_LSB +: 6];
            evt.press_en <= pwdata[`VSYN_EVT_PRESS_EN_BIT];
            evt.rel_key <= pwdata[`VSYN_EVT_REL_KEY_LSB +: 6];
            evt.rel_en <= pwdata[`VSYN_EVT_REL_EN_BIT];
            rel_pend <= pwdata[`VSYN_EVT_REL_EN_BIT];
            // out-of-range keys are never loaded into a slot
            press_pend <= pwdata[`VSYN_EVT_PRESS_EN_BIT]
                && (pwdata[`VSYN_EVT_PRESS_KEY_LSB +: 6] < 6'd37);
        end
        else
        begin
            if (rel_go)
                rel_pend <= 1'b0;
            if (press_go)
                press_pend <= 1'b0;
        end
    end

    // sticky drop flag: a new drop wins over a software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drop_flag <= 1'b0;
        else if (press_go && free_idx == 4'hF)
            drop_flag <= 1'b1;
        else if (psel && penable && pready && pwrite
                 && paddr == `VSYN_ADDR_STATUS
                 && pwdata[`VSYN_STAT_DROP_BIT])
            drop_flag <= 1'b0;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TICK_TO_SAMPLE: assert property (
        tick |-> ##11 sample_strobe)
        else $error("sample not produced 11 cycles after tick");
    AST_TICK_SPACING: assert property (tick |=> !tick [*8])
        else $error("ticks too close together");
    AST_ACC_CLEARED: assert property (
        upd && vidx == 4'h0 |-> acc == 20'h0)
        else $error("accumulator not cleared at sample start");
    AST_FREE_SILENT: assert property (
        upd && cur_free |-> prod == 16'h0)
        else $error("free slot added to mix");
    AST_OVERFLOW_FREES: assert property (
        upd && !cur_free && e_carry
        |=> voices[$past(vidx)].state == 8'hFF)
        else $error("finished voice not freed");
    AST_PRESS_LOAD: assert property (
        press_go && free_idx != 4'hF
        |=> voices[$past(free_idx)].state == {2'b00, $past(evt.press_key)}
            && voices[$past(free_idx)].ephase == 20'h0)
        else $error("press did not load free slot");
    AST_NO_FREE: assert property (
        press_go && free_idx == 4'hF |=> busy_map() == 10'h3FF && drop_flag)
        else $error("press without free slot disturbed voices");
    // the press of a result must follow its release at the next idle cycle
    AST_REL_FIRST: assert property (
        rel_go && press_pend |=> (press_go || tick))
        else $error("press not handled right after release");
    // worst case: tick right after the write, ten update cycles, two events
    AST_EVT_BOUND: assert property (
        evt_take |-> ##[1:14] (!rel_pend && !press_pend))
        else $error("scan result still pending 14 cycles on");
    AST_RELEASE_SET: assert property (
        rel_go && voices[0].state == {2'b00, evt.rel_key}
        |=> voices[0].release_rate)
        else $error("released key kept sustain rate");
    AST_SLOT_VALUE: assert property (
        voices[vidx < 4'd10 ? vidx : 4'd0].state < 8'd37 || cur_free)
        else $error("slot holds invalid key");

    COV_SAMPLE: cover property (sample_strobe && mix_output != 8'h00);
    COV_DROP: cover property (press_go && free_idx == 4'hF);
    COV_RELEASE: cover property (rel_go ##[1:20] press_go);
    COV_RETIRE: cover property (upd && !cur_free && e_carry);
endmodule

// File: sim/vsyn_dac_model.sv
/*
 * DAC side of the voice engine: latches the mix word at each strobe
 * and measures the spacing of strobes in clock cycles.
 * Assumes the engine's pclk and presetn.
 */
`timescale 1ns/1ps
module vsyn_dac_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // engine output
    input wire logic [7:0] mix_output,
    input wire logic sample_strobe,
    // what the converter saw
    output logic [7:0] dac_level,
    output logic [31:0] gap,
    output logic [31:0] samples
);
    logic [31:0] since;

    // update register of the converter; a stuck strobe shows as gap 1
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_level <= 8'h00;
            gap <= 32'h0;
            samples <= 32'h0;
            since <= 32'h0;
        end
        else if (sample_strobe)
        begin
            dac_level <= mix_output;
            gap <= since + 32'h1;
            samples <= samples + 32'h1;
            since <= 32'h0;
        end
        else
            since <= since + 32'h1;
    end
endmodule

// File: sim/polyphonic_voice_synth_test.sv
/*
 * Self-checking bench of the voice engine: plays the scan side over
 * APB and watches the DAC side through the converter model.
 * Assumes vsyn_defines.svh on the include path and a short TICK_DIV.
 */
`timescale 1ns/1ps
`include "vsyn_defines.svh"
module polyphonic_voice_synth_test;
    import vsyn_pkg::*;
    localparam int unsigned TDIV = 40;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] mix_output;
    logic sample_strobe;
    logic [7:0] dac_level;
    logic [31:0] gap;
    logic [31:0] samples;
    logic [31:0] rd;
    logic err;
    logic [5:0] k;
    logic [5:0] keys [10];
    integer seed;
    int errors;
    int cmp_count;
    int polls;

    vsyn_engine #(.TICK_DIV(TDIV)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mix_output(mix_output), .sample_strobe(sample_strobe)
    );

    vsyn_dac_model dac (
        .pclk(pclk), .presetn(presetn), .mix_output(mix_output),
        .sample_strobe(sample_strobe), .dac_level(dac_level),
        .gap(gap), .samples(samples)
    );

    // 250 MHz
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen,
                     exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 200)
        begin
            errors++;
            finish_test();
        end
    endtask

    function automatic logic [31:0] evt(input logic pe, input logic [5:0] pk,
                                        input logic re, input logic [5:0] rk);
        evt = 32'h0;
        evt[`VSYN_EVT_PRESS_KEY_LSB +: 6] = pk;
        evt[`VSYN_EVT_PRESS_EN_BIT] = pe;
        evt[`VSYN_EVT_REL_KEY_LSB +: 6] = rk;
        evt[`VSYN_EVT_REL_EN_BIT] = re;
    endfunction

    // post a scan result, then wait until the engine has taken it
    task automatic send(input logic [31:0] e);
        int n;
        apb(1'b1, `VSYN_ADDR_KEY_EVT, e);
        n = 0;
        do
        begin
            apb(1'b0, `VSYN_ADDR_STATUS, 32'h0);
            n++;
        end
        while (rd[`VSYN_STAT_PEND_BIT] !== 1'b0 && n < 60);
        // a result still pending after the poll limit counts as a mismatch
        check({31'h0, rd[`VSYN_STAT_PEND_BIT]}, 32'h0);
        apb(1'b0, `VSYN_ADDR_VOICE_BUSY, 32'h0);
    endtask

    // poll the busy mask once a tick; release takes at most 256 ticks
    task automatic wait_busy(input logic [31:0] exp);
        int n;
        n = 0;
        do
        begin
            repeat (TDIV) @(posedge pclk);
            apb(1'b0, `VSYN_ADDR_VOICE_BUSY, 32'h0);
            n++;
        end
        while (rd !== exp && n < 300);
    endtask

    initial
    begin
        seed = 32'h608B;
        errors = 0;
        cmp_count = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset state and register map
        apb(1'b0, `VSYN_ADDR_VOICE_BUSY, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `VSYN_ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `VSYN_ADDR_KEY_EVT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, `VSYN_ADDR_VOICE_BUSY, 32'hFFFFFFFF);
        apb(1'b0, `VSYN_ADDR_VOICE_BUSY, 32'h0);
        check(rd, 32'h0);
        $display("test registers done");
        // keys beyond the step table must not claim a slot
        repeat (4)
        begin
            k = 6'(37 + (($random(seed) & 32'h7FFF) % 27));
            send(evt(1'b1, k, 1'b0, 6'h00));
            check(rd, 32'h0);
        end
        // silent engine still strobes at the divided rate
        repeat (3 * TDIV) @(posedge pclk);
        check(gap, TDIV);
        check({31'h0, samples >= 32'h2}, 32'h1);
        check({24'h0, dac_level}, 32'h0);
        $display("test tick done");
        // fill all ten slots lowest first, then overflow one press
        for (int i = 0; i < 10; i++)
        begin
            keys[i] = 6'(($random(seed) & 32'h7FFF) % 37);
            send(evt(1'b1, keys[i], 1'b0, 6'h00));
            check(rd, (32'h1 << (i + 1)) - 32'h1);
        end
        send(evt(1'b1, 6'h24, 1'b0, 6'h00));
        check(rd, 32'h3FF);
        apb(1'b0, `VSYN_ADDR_STATUS, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, `VSYN_ADDR_STATUS, 32'h2);
        apb(1'b0, `VSYN_ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        // envelopes sit at entry zero for the first ticks, so wait first
        repeat (100 * TDIV) @(posedge pclk);
        apb(1'b0, `VSYN_ADDR_VOICE_BUSY, 32'h0);
        check(rd, 32'h3FF);
        // full sum and dac word must agree; read just after a strobe
        polls = 0;
        while (sample_strobe !== 1'b1 && polls < 2 * TDIV)
        begin
            @(posedge pclk);
            polls++;
        end
        check({31'h0, sample_strobe}, 32'h1);
        apb(1'b0, `VSYN_ADDR_MIX, 32'h0);
        check({rd[31:20], 12'h0, rd[19:12]}, {24'h0, dac_level});
        check({31'h0, rd != 32'h0}, 32'h1);
        // ten products of at most 255 by 255
        check({31'h0, rd <= 32'h0009EC0A}, 32'h1);
        $display("test fill done");
        // released voices keep sounding, then retire on overflow
        for (int i = 0; i < 10; i++)
            send(evt(1'b0, 6'h00, 1'b1, keys[i]));
        check(rd, 32'h3FF);
        wait_busy(32'h0);
        check(rd, 32'h0);
        repeat (2 * TDIV) @(posedge pclk);
        check({24'h0, dac_level}, 32'h0);
        $display("test release done");
        // release and press of one key in one result: release first
        send(evt(1'b1, 6'h09, 1'b0, 6'h00));
        check(rd, 32'h1);
        send(evt(1'b1, 6'h09, 1'b1, 6'h09));
        check(rd, 32'h3);
        wait_busy(32'h2);
        check(rd, 32'h2);
        // a press handled before the release would be fading as well
        repeat (8 * TDIV) @(posedge pclk);
        apb(1'b0, `VSYN_ADDR_VOICE_BUSY, 32'h0);
        check(rd, 32'h2);
        send(evt(1'b0, 6'h00, 1'b1, 6'h09));
        wait_busy(32'h0);
        check(rd, 32'h0);
        $display("test order done");
        finish_test();
    end
endmodule
